// ---- pkg/limit_monitor_pkg.sv ----
// constants, field layout and types shared by the limit monitor files
// assumes one 200 MHz clock and a register port indexed by word address

package limit_monitor_pkg;

	// ==========================================================
	// sizes
	localparam int NUM_CH = 16;
	localparam int NUM_LIM = 4;
	localparam int DATA_W = 16;
	localparam int ADDR_W = 9;
	localparam int CH_W = 4;
	localparam int LIM_W = 2;
	localparam int TIME_W = 32;
	localparam int IRQ_W = 3;

	// ==========================================================
	// global register offsets (word index on the register port)
	localparam logic [8:0] OFF_IRQ_STATUS = 9'h000;
	localparam logic [8:0] OFF_IRQ_CLEAR = 9'h001;
	localparam logic [8:0] OFF_IRQ_ENABLE = 9'h002;
	localparam logic [8:0] OFF_RUN = 9'h003;
	localparam logic [8:0] OFF_MODULE_TYPE = 9'h004;
	localparam logic [8:0] OFF_TIME_LO = 9'h005;
	localparam logic [8:0] OFF_TIME_HI = 9'h006;

	// channel blocks: bit 8 set, bits 7:4 channel, bits 3:0 select
	localparam int CH_REGION_BIT = 8;
	localparam logic [3:0] SEL_CTRL = 4'h0;
	localparam logic [3:0] SEL_HYST = 4'h1;
	localparam logic [3:0] SEL_SIM_VALUE = 4'h2;
	localparam logic [3:0] SEL_STATUS = 4'h3;
	localparam logic [3:0] SEL_LIMIT0 = 4'h4;

	// ==========================================================
	// channel control word fields
	localparam int CTRL_EN_LSB = 0;
	localparam int CTRL_DIR_LSB = 4;
	localparam int CTRL_SUB_LSB = 8;
	localparam int CTRL_SUB_EN = 12;
	localparam int CTRL_SIG_EN = 13;
	localparam int CTRL_SIM_EN = 14;

	// channel status word fields
	localparam int STAT_STATE_LSB = 0;
	localparam int STAT_INV_LSB = 4;
	localparam int STAT_SIM = 8;

	// interrupt bits
	localparam int IRQ_LIMIT = 0;
	localparam int IRQ_SIM = 1;
	localparam int IRQ_SUBST = 2;

	// ==========================================================
	// reset values
	localparam logic [15:0] CTRL_RST = 16'h0000;
	localparam logic [15:0] HYST_RST = 16'h0000;
	localparam logic [15:0] LIMIT_RST = 16'h0000;
	localparam logic [15:0] SIM_VALUE_RST = 16'h0000;
	localparam logic [2:0] IRQ_EN_RST = 3'h0;

	// value is arbitrary, only used to let software recognise the block
	localparam logic [15:0] MODULE_TYPE = 16'h5a3c;

	// ==========================================================
	// timing: time tag advances once per millisecond
	localparam int CLK_PERIOD_PS = 5000;
	localparam int TIME_TICK_US = 1000;
	localparam int TIME_TICK_CYCLES = (TIME_TICK_US * 1000 * 1000) / CLK_PERIOD_PS;

	// ==========================================================
	// message kinds
	typedef enum logic [1:0] {MSG_LIMIT, MSG_SIM_SIGNAL, MSG_SIM_ERROR} msg_kind_e;

endpackage

// ---- pkg/monitor_link_if.sv ----
// internal links of the limit monitor: evaluator inputs/outputs and the message serializer
// assumes all parties on core_clk

`timescale 1ns/1ps

interface monitor_link_if;
	// evaluator group
	logic [15:0] value;
	logic [3:0][15:0] limits;
	logic [15:0] hyst;
	logic [3:0] upper;
	logic [3:0] prev;
	logic [3:0] next;
	// serializer load group
	logic load;
	logic [3:0] chan;
	logic [3:0] changed;
	logic [3:0] state;
	logic sim_change;
	logic sim_state;
	logic sig_en;
	logic [31:0] stamp;
	// serializer output group
	logic busy;
	logic out_valid;
	limit_monitor_pkg::msg_kind_e out_kind;
	logic [3:0] out_chan;
	logic [1:0] out_limit;
	logic out_state;
	logic [31:0] out_time;

	modport top (
		output value, limits, hyst, upper, prev,
		input next,
		output load, chan, changed, state, sim_change, sim_state, sig_en, stamp,
		input busy, out_valid, out_kind, out_chan, out_limit, out_state, out_time
	);
	modport eval (
		input value, limits, hyst, upper, prev,
		output next
	);
	modport ser (
		input load, chan, changed, state, sim_change, sim_state, sig_en, stamp,
		output busy, out_valid, out_kind, out_chan, out_limit, out_state, out_time
	);
endinterface

// ---- rtl/limit_eval.sv ----
// combinational limit evaluation of one channel, all limits in parallel
// assumes inputs are stable registered values from the top

`timescale 1ns/1ps

module limit_eval
(
	// evaluator side of the link
	monitor_link_if.eval lk
);

	// ==========================================================
	// one limit with hysteresis; 18-bit signed so limit minus hysteresis can go negative
	function automatic logic next_bit(input logic [15:0] v, input logic [15:0] lim, input logic [15:0] limit_hysteresis,
		input logic up, input logic prev);
		logic signed [17:0] vs;
		logic signed [17:0] ls;
		logic signed [17:0] th;
		logic set_c;
		logic clr_c;
		vs = signed'({2'b00, v});
		ls = signed'({2'b00, lim});
		th = ls - signed'({2'b00, limit_hysteresis});
		if (up)
		begin
			set_c = (vs >= ls);
			clr_c = (vs < th);
		end
		else
		begin
			set_c = (vs <= ls);
			clr_c = (vs > th);
		end
		if (set_c)
			return 1'b1;
		else if (clr_c)
			return 1'b0;
		else
			return prev;
	endfunction

	always_comb
	begin
		for (int i = 0; i < limit_monitor_pkg::NUM_LIM; i++)
		begin
			lk.next[i] = next_bit(lk.value, lk.limits[i], lk.hyst, lk.upper[i], lk.prev[i]);
		end
	end

endmodule

// ---- rtl/msg_serializer.sv ----
// turns one channel's batch of state changes into single-cycle time-tagged messages
// assumes the top loads only while busy is low; the receiver takes one message per cycle

`timescale 1ns/1ps

module msg_serializer
(
	// clock and reset
	input wire logic core_clk,
	input wire logic sys_rst,
	// serializer side of the link
	monitor_link_if.ser lk
);

	typedef struct packed {
		logic [3:0] pend;
		logic pend_err;
		logic pend_sig;
		logic [3:0] chan;
		logic [3:0] state;
		logic sim_state;
		logic [31:0] stamp;
		logic busy;
		logic out_valid;
		limit_monitor_pkg::msg_kind_e out_kind;
		logic [3:0] out_chan;
		logic [1:0] out_limit;
		logic out_state;
		logic [31:0] out_time;
	} ser_state_s;

	ser_state_s s_r;
	ser_state_s s_nxt;

	// ==========================================================
	// pick lowest pending limit first, then sim error, then sim signal
	always_comb
	begin
		s_nxt = s_r;
		s_nxt.out_valid = 1'b0;
		if (lk.load)
		begin
			s_nxt.pend = lk.changed;
			s_nxt.pend_err = lk.sim_change;
			s_nxt.pend_sig = lk.sim_change & lk.sig_en;
			s_nxt.chan = lk.chan;
			s_nxt.state = lk.state;
			s_nxt.sim_state = lk.sim_state;
			s_nxt.stamp = lk.stamp;
		end
		else if (s_r.pend != 4'h0)
		begin
			s_nxt.out_valid = 1'b1;
			s_nxt.out_kind = limit_monitor_pkg::MSG_LIMIT;
			s_nxt.out_chan = s_r.chan;
			s_nxt.out_time = s_r.stamp;
			for (int i = limit_monitor_pkg::NUM_LIM - 1; i >= 0; i--)
			begin
				if (s_r.pend[i])
				begin
					s_nxt.out_limit = 2'(i);
					s_nxt.out_state = s_r.state[i];
				end
			end
			s_nxt.pend = s_r.pend & (s_r.pend - 4'h1);
		end
		else if (s_r.pend_err)
		begin
			s_nxt.out_valid = 1'b1;
			s_nxt.out_kind = limit_monitor_pkg::MSG_SIM_ERROR;
			s_nxt.out_chan = s_r.chan;
			s_nxt.out_limit = 2'h0;
			s_nxt.out_state = s_r.sim_state;
			s_nxt.out_time = s_r.stamp;
			s_nxt.pend_err = 1'b0;
		end
		else if (s_r.pend_sig)
		begin
			s_nxt.out_valid = 1'b1;
			s_nxt.out_kind = limit_monitor_pkg::MSG_SIM_SIGNAL;
			s_nxt.out_chan = s_r.chan;
			s_nxt.out_limit = 2'h0;
			s_nxt.out_state = s_r.sim_state;
			s_nxt.out_time = s_r.stamp;
			s_nxt.pend_sig = 1'b0;
		end
		s_nxt.busy = (s_nxt.pend != 4'h0) | s_nxt.pend_err | s_nxt.pend_sig;
	end

	// state register
	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
			s_r <= '0;
		else
			s_r <= s_nxt;
	end

	// outputs straight from the state register
	assign lk.busy = s_r.busy;
	assign lk.out_valid = s_r.out_valid;
	assign lk.out_kind = s_r.out_kind;
	assign lk.out_chan = s_r.out_chan;
	assign lk.out_limit = s_r.out_limit;
	assign lk.out_state = s_r.out_state;
	assign lk.out_time = s_r.out_time;

endmodule

// ---- rtl/analog_limit_signal_monitor.sv ----
// top of the 16-channel limit signal monitor: registers, simulation path, process image, messages
// assumes conditioned samples and channel faults come from logic on core_clk, held until sample_ready
//
// Overview of operation
// - per-channel enable, direction and hysteresis
// - four limits per channel, one hysteresis
// - upper: set when value >= limit
// - upper: clear below limit minus hysteresis
// - lower: set when value <= limit
// - lower: clear above limit minus hysteresis
// - image holds limit and its complement
// - time-tagged message on each limit change
// - fault substitutes predefined limit states
// - simulated value replaces measured input
// - simulated channel error plus signal message
// - simulated flag set in process image
// - type recognised, run only after initialisation
//
// Added by the designer: strobed register access and the register offsets.

`timescale 1ns/1ps

module analog_limit_signal_monitor
#(
	parameter int TICK_CYCLES = limit_monitor_pkg::TIME_TICK_CYCLES
)
(
	// clock and reset
	input wire logic core_clk,
	input wire logic sys_rst,
	// register port
	input wire logic [8:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	// conditioned samples from the conversion front end
	input wire logic sample_valid,
	input wire logic [3:0] sample_chan,
	input wire logic [15:0] sample_value,
	output logic sample_ready,
	input wire logic [15:0] chan_fault,
	// input process image
	output logic [63:0] limit_image,
	output logic [63:0] limit_image_inv,
	output logic [15:0] sim_image,
	// time-tagged messages
	output logic msg_valid,
	output limit_monitor_pkg::msg_kind_e msg_kind,
	output logic [3:0] msg_chan,
	output logic [1:0] msg_limit,
	output logic msg_state,
	output logic [31:0] msg_time,
	// interrupt
	output logic irq
);

	localparam int NCH = limit_monitor_pkg::NUM_CH;
	localparam int NLIM = limit_monitor_pkg::NUM_LIM;

	typedef struct packed {
		logic [NCH-1:0][15:0] ctrl;
		logic [NCH-1:0][15:0] hyst;
		logic [NCH-1:0][15:0] sim_value;
		logic [NCH*NLIM-1:0][15:0] limit;
		logic [NCH*NLIM-1:0] lim_state;
		logic [NCH*NLIM-1:0] lim_inv;
		logic [NCH-1:0] sim_flag;
		logic run;
		logic [2:0] irq_stat;
		logic [2:0] irq_en;
		logic irq;
		logic [15:0] rdata;
		logic ready;
		logic stg_v;
		logic [3:0] stg_ch;
		logic [15:0] stg_val;
		logic [17:0] tick_cnt;
		logic [31:0] time_tag;
	} top_state_s;

	top_state_s s_r;
	top_state_s s_nxt;

	monitor_link_if lk ();

	// ==========================================================
	// sub-blocks
	limit_eval u_eval
	(
		.lk(lk.eval)
	);

	msg_serializer u_ser
	(
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.lk(lk.ser)
	);

	// ==========================================================
	// decode helpers
	function automatic logic is_chan(input logic [8:0] a);
		return a[limit_monitor_pkg::CH_REGION_BIT];
	endfunction

	function automatic logic [5:0] lim_index(input logic [3:0] ch, input logic [3:0] sel);
		return {ch, 2'(sel - limit_monitor_pkg::SEL_LIMIT0)};
	endfunction

	// working values of the channel in the stage
	logic [15:0] st_ctrl;
	logic [3:0] st_en;
	logic [3:0] st_new;
	logic [3:0] st_old;
	logic [3:0] st_chg;
	logic st_sub;
	logic st_sim;
	logic st_sim_chg;

	// ==========================================================
	// evaluator inputs come from the stage register and stored parameters
	always_comb
	begin
		lk.value = s_r.stg_val;
		lk.hyst = s_r.hyst[s_r.stg_ch];
		lk.upper = st_ctrl[limit_monitor_pkg::CTRL_DIR_LSB +: 4];
		lk.prev = st_old;
		for (int i = 0; i < NLIM; i++)
		begin
			lk.limits[i] = s_r.limit[{s_r.stg_ch, 2'(i)}];
		end
	end

	// ==========================================================
	// channel outcome: substitution, masking and change detection
	always_comb
	begin
		st_ctrl = s_r.ctrl[s_r.stg_ch];
		st_en = st_ctrl[limit_monitor_pkg::CTRL_EN_LSB +: 4];
		st_old = s_r.lim_state[{s_r.stg_ch, 2'b00} +: 4];
		st_sub = st_ctrl[limit_monitor_pkg::CTRL_SUB_EN] & chan_fault[s_r.stg_ch] & (st_en != 4'h0);
		if (st_sub)
			st_new = st_ctrl[limit_monitor_pkg::CTRL_SUB_LSB +: 4] & st_en;
		else
			st_new = lk.next & st_en;
		st_chg = st_new ^ st_old;
		st_sim = st_ctrl[limit_monitor_pkg::CTRL_SIM_EN];
		st_sim_chg = st_sim ^ s_r.sim_flag[s_r.stg_ch];
	end

	// ==========================================================
	// serializer load comes from the stage; limit messages only where enabled
	always_comb
	begin
		lk.load = s_r.stg_v;
		lk.chan = s_r.stg_ch;
		lk.changed = st_ctrl[limit_monitor_pkg::CTRL_SIG_EN] ? st_chg : 4'h0;
		lk.state = st_new;
		lk.sim_change = st_sim_chg;
		lk.sim_state = st_sim;
		lk.sig_en = st_ctrl[limit_monitor_pkg::CTRL_SIG_EN];
		lk.stamp = s_r.time_tag;
	end

	// ==========================================================
	// next state of the whole top
	always_comb
	begin
		logic accept;
		logic [2:0] ev;
		logic [2:0] clr;
		logic [3:0] sel;
		logic [3:0] ch;
		s_nxt = s_r;
		ev = 3'h0;
		clr = 3'h0;
		sel = reg_addr[3:0];
		ch = reg_addr[7:4];

		// time tag: millisecond enable from a divider
		if (s_r.tick_cnt == 18'(TICK_CYCLES - 1))
		begin
			s_nxt.tick_cnt = 18'h0_0000;
			s_nxt.time_tag = s_r.time_tag + 32'h0000_0001;
		end
		else
		begin
			s_nxt.tick_cnt = s_r.tick_cnt + 18'h0_0001;
		end

		accept = sample_valid & s_r.ready & s_r.run;
		if (accept)
		begin
			s_nxt.stg_v = 1'b1;
			s_nxt.stg_ch = sample_chan;
			if (s_r.ctrl[sample_chan][limit_monitor_pkg::CTRL_SIM_EN])
				s_nxt.stg_val = s_r.sim_value[sample_chan];
			else
				s_nxt.stg_val = sample_value;
		end
		else
		begin
			s_nxt.stg_v = 1'b0;
		end
		// one channel in flight; ready drops while the stage or serializer works
		s_nxt.ready = ~accept & ~s_r.stg_v & ~lk.busy;

		// commit the stage result to the process image
		if (s_r.stg_v)
		begin
			s_nxt.lim_state[{s_r.stg_ch, 2'b00} +: 4] = st_new;
			s_nxt.lim_inv[{s_r.stg_ch, 2'b00} +: 4] = ~st_new & st_en;
			s_nxt.sim_flag[s_r.stg_ch] = st_sim;
			ev[limit_monitor_pkg::IRQ_LIMIT] = (st_chg != 4'h0);
			ev[limit_monitor_pkg::IRQ_SIM] = st_sim_chg;
			ev[limit_monitor_pkg::IRQ_SUBST] = st_sub;
		end

		// register writes
		if (reg_wr)
		begin
			if (is_chan(reg_addr))
			begin
				case (sel)
					limit_monitor_pkg::SEL_CTRL: s_nxt.ctrl[ch] = reg_wdata;
					limit_monitor_pkg::SEL_HYST: s_nxt.hyst[ch] = reg_wdata;
					limit_monitor_pkg::SEL_SIM_VALUE: s_nxt.sim_value[ch] = reg_wdata;
					4'h4, 4'h5, 4'h6, 4'h7: s_nxt.limit[lim_index(ch, sel)] = reg_wdata;
					default: ;
				endcase
			end
			else
			begin
				case (reg_addr)
					limit_monitor_pkg::OFF_IRQ_CLEAR: clr = reg_wdata[2:0];
					limit_monitor_pkg::OFF_IRQ_ENABLE: s_nxt.irq_en = reg_wdata[2:0];
					limit_monitor_pkg::OFF_RUN: s_nxt.run = reg_wdata[0];
					default: ;
				endcase
			end
		end

		// sticky status: a new event wins over a clear in the same cycle
		s_nxt.irq_stat = (s_r.irq_stat & ~clr) | ev;
		s_nxt.irq = |(s_nxt.irq_stat & s_nxt.irq_en);

		// register reads: data stands only in the cycle after the strobe
		s_nxt.rdata = 16'h0000;
		if (reg_rd)
		begin
			if (is_chan(reg_addr))
			begin
				case (sel)
					limit_monitor_pkg::SEL_CTRL: s_nxt.rdata = s_r.ctrl[ch];
					limit_monitor_pkg::SEL_HYST: s_nxt.rdata = s_r.hyst[ch];
					limit_monitor_pkg::SEL_SIM_VALUE: s_nxt.rdata = s_r.sim_value[ch];
					limit_monitor_pkg::SEL_STATUS:
					begin
						s_nxt.rdata[limit_monitor_pkg::STAT_STATE_LSB +: 4] = s_r.lim_state[{ch, 2'b00} +: 4];
						s_nxt.rdata[limit_monitor_pkg::STAT_INV_LSB +: 4] = s_r.lim_inv[{ch, 2'b00} +: 4];
						s_nxt.rdata[limit_monitor_pkg::STAT_SIM] = s_r.sim_flag[ch];
					end
					4'h4, 4'h5, 4'h6, 4'h7: s_nxt.rdata = s_r.limit[lim_index(ch, sel)];
					default: ;
				endcase
			end
			else
			begin
				case (reg_addr)
					limit_monitor_pkg::OFF_IRQ_STATUS: s_nxt.rdata = {13'h0000, s_r.irq_stat};
					limit_monitor_pkg::OFF_IRQ_ENABLE: s_nxt.rdata = {13'h0000, s_r.irq_en};
					limit_monitor_pkg::OFF_RUN: s_nxt.rdata = {15'h0000, s_r.run};
					limit_monitor_pkg::OFF_MODULE_TYPE: s_nxt.rdata = limit_monitor_pkg::MODULE_TYPE;
					limit_monitor_pkg::OFF_TIME_LO: s_nxt.rdata = s_r.time_tag[15:0];
					limit_monitor_pkg::OFF_TIME_HI: s_nxt.rdata = s_r.time_tag[31:16];
					default: ;
				endcase
			end
		end
	end

	// ==========================================================
	// state register; every reset value of the block is zero
	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			s_r <= '0;
			s_r.irq_en <= limit_monitor_pkg::IRQ_EN_RST;
		end
		else
		begin
			s_r <= s_nxt;
		end
	end

	// ==========================================================
	// outputs straight from flip-flops
	assign reg_rdata = s_r.rdata;
	assign sample_ready = s_r.ready;
	assign limit_image = s_r.lim_state;
	assign limit_image_inv = s_r.lim_inv;
	assign sim_image = s_r.sim_flag;
	assign irq = s_r.irq;
	// message fields are the serializer's own registers
	assign msg_valid = lk.out_valid;
	assign msg_kind = lk.out_kind;
	assign msg_chan = lk.out_chan;
	assign msg_limit = lk.out_limit;
	assign msg_state = lk.out_state;
	assign msg_time = lk.out_time;

endmodule

// ---- dv/limit_monitor_assertions.sv ----
// checker for the limit monitor, watching the top ports only
// assumes one clock domain with a synchronous active-high reset
`timescale 1ns/1ps
module limit_monitor_checker
#(
	parameter int TICK_CYCLES = 8
)
(
	// clock and reset
	input wire logic core_clk,
	input wire logic sys_rst,
	// register port
	input wire logic [8:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [15:0] reg_rdata,
	// samples
	input wire logic sample_valid,
	input wire logic sample_ready,
	// image, messages, interrupt
	input wire logic [63:0] limit_image,
	input wire logic [63:0] limit_image_inv,
	input wire logic [15:0] sim_image,
	input wire logic msg_valid,
	input wire limit_monitor_pkg::msg_kind_e msg_kind,
	input wire logic [3:0] msg_chan,
	input wire logic [1:0] msg_limit,
	input wire logic msg_state,
	input wire logic irq
);
	logic run_r;
	logic take;
	// ==========================================================
	// shadow of the run bit, a sample only counts as taken while running
	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
			run_r <= 1'b0;
		else if (reg_wr && reg_addr == limit_monitor_pkg::OFF_RUN)
			run_r <= reg_wdata[0];
	end
	assign take = sample_valid && sample_ready && run_r;
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (sys_rst);
	// ==========================================================
	// assertions
	a_image_inv_apart: assert property ((limit_image & limit_image_inv) == 64'h0000_0000_0000_0000)
		else $error("limit bit and its complement both set");
	a_limit_msg_state: assert property (msg_valid && msg_kind == limit_monitor_pkg::MSG_LIMIT |-> limit_image[{msg_chan, msg_limit}] == msg_state)
		else $error("limit message state differs from image");
	a_sim_msg_flag: assert property (msg_valid && msg_kind == limit_monitor_pkg::MSG_SIM_ERROR |-> sim_image[msg_chan] == msg_state)
		else $error("sim error message differs from sim flag");
	// reset clears the images, so a change right after reset is not an event
	a_sim_err_follows: assert property (!$past(sys_rst) && $changed(sim_image) |-> ##[1:8] (msg_valid && msg_kind == limit_monitor_pkg::MSG_SIM_ERROR))
		else $error("sim flag change without sim error message");
	// take at edge t, stage at t+1, image commits at t+1 and is first sampled at t+2
	a_image_hold_idle: assert property (!$past(sys_rst) && ($changed(limit_image) || $changed(sim_image)) |-> $past(take, 2))
		else $error("image changed without a processed sample");
	a_ready_gap_two: assert property (take |=> !sample_ready [*2])
		else $error("sample ready returned too early");
	a_type_read_back: assert property ($past(reg_rd) && $past(reg_addr) == limit_monitor_pkg::OFF_MODULE_TYPE |-> reg_rdata == limit_monitor_pkg::MODULE_TYPE)
		else $error("module type read wrong");
	a_rdata_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
		else $error("read data outside read answer cycle");
	// ==========================================================
	// covers
	c_limit_msg: cover property (msg_valid && msg_kind == limit_monitor_pkg::MSG_LIMIT);
	c_sim_err: cover property (msg_valid && msg_kind == limit_monitor_pkg::MSG_SIM_ERROR);
	c_irq_rise: cover property ($rose(irq));
endmodule

bind analog_limit_signal_monitor limit_monitor_checker #(.TICK_CYCLES(TICK_CYCLES)) chk_u
(
	.core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata), .sample_valid(sample_valid), .sample_ready(sample_ready),
	.limit_image(limit_image), .limit_image_inv(limit_image_inv), .sim_image(sim_image), .msg_valid(msg_valid),
	.msg_kind(msg_kind), .msg_chan(msg_chan), .msg_limit(msg_limit), .msg_state(msg_state), .irq(irq)
);

// ---- dv/host_model.sv ----
// higher-level processor model: register bus master and message log
// assumes the monitor samples its register port on core_clk
`timescale 1ns/1ps
module host_model
(
	// clock
	input wire logic core_clk,
	// register port
	output logic [8:0] reg_addr,
	output logic [15:0] reg_wdata,
	output logic reg_wr,
	output logic reg_rd,
	input wire logic [15:0] reg_rdata,
	// messages
	input wire logic msg_valid,
	input wire limit_monitor_pkg::msg_kind_e msg_kind
);
	int lim_msgs = 0;
	int sim_msgs = 0;
	// ==========================================================
	// bus idle at time zero
	initial
	begin
		reg_addr = 9'h000;
		reg_wdata = 16'h0000;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end
	// one-cycle write; stale data inverted so it never looks valid
	task automatic wr(input logic [8:0] a, input logic [15:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
		reg_wdata <= ~d;
	endtask
	task automatic rd(input logic [8:0] a, output logic [15:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask
	// count messages at the falling edge, away from the edge that launches them
	always @(negedge core_clk)
	begin
		if (msg_valid === 1'b1 && msg_kind === limit_monitor_pkg::MSG_LIMIT)
			lim_msgs++;
		if (msg_valid === 1'b1 && msg_kind === limit_monitor_pkg::MSG_SIM_ERROR)
			sim_msgs++;
	end
endmodule

// ---- dv/testbench.sv ----
// self-checking bench of the limit monitor
// assumes the host model issues register cycles; samples driven here
`timescale 1ns/1ps
`define CHK(nm, ex, ac) begin samples_checked++; if ((ac) !== (ex)) begin err_count++; $display("mismatch %s expected %h seen %h", nm, ex, ac); end end
module testbench;
	logic core_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic sample_valid = 1'b0;
	logic [3:0] sample_chan = 4'h0;
	logic [15:0] sample_value = 16'h0000;
	logic [15:0] chan_fault = 16'h0000;
	logic [8:0] reg_addr;
	logic [15:0] reg_wdata, reg_rdata, sim_image, v;
	logic reg_wr, reg_rd, sample_ready, msg_valid, msg_state, irq;
	logic [63:0] limit_image, limit_image_inv;
	limit_monitor_pkg::msg_kind_e msg_kind;
	logic [3:0] msg_chan;
	logic [1:0] msg_limit;
	logic [31:0] msg_time;
	int err_count = 0;
	int samples_checked = 0;
	int cycles = 0;
	// ==========================================================
	// clock, instances, hang guard
	initial
	begin
		forever #2.5 core_clk = ~core_clk;
	end
	analog_limit_signal_monitor #(.TICK_CYCLES(8)) dut_u
	(
		.core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .sample_valid(sample_valid), .sample_chan(sample_chan),
		.sample_value(sample_value), .sample_ready(sample_ready), .chan_fault(chan_fault), .limit_image(limit_image),
		.limit_image_inv(limit_image_inv), .sim_image(sim_image), .msg_valid(msg_valid), .msg_kind(msg_kind),
		.msg_chan(msg_chan), .msg_limit(msg_limit), .msg_state(msg_state), .msg_time(msg_time), .irq(irq)
	);
	host_model host_u
	(
		.core_clk(core_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .msg_valid(msg_valid), .msg_kind(msg_kind)
	);
	// whole run needs well under a thousand cycles
	always @(posedge core_clk)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			err_count++;
			close_out();
		end
	end
	task automatic close_out();
		$display("checks %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// ==========================================================
	// offer one sample, then wait until the monitor is ready again
	task automatic send(input logic [3:0] ch, input logic [15:0] val);
		int n;
		n = 0;
		@(posedge core_clk);
		sample_chan <= ch;
		sample_value <= val;
		sample_valid <= 1'b1;
		do @(negedge core_clk); while (sample_ready !== 1'b1 && ++n < 50);
		@(posedge core_clk);
		sample_valid <= 1'b0;
		sample_value <= ~val;
		repeat (2) @(negedge core_clk);
		while (sample_ready !== 1'b1 && n < 100)
		begin
			@(negedge core_clk);
			n++;
		end
	endtask
	task automatic irq_after_write(input logic [8:0] a, input logic [15:0] d, input logic ex);
		host_u.wr(a, d);
		repeat (2) @(negedge core_clk);
		`CHK("irq", ex, irq)
	endtask
	// ==========================================================
	// scenarios
	task automatic t_regs();
		host_u.rd(9'h004, v);
		`CHK("module_type", limit_monitor_pkg::MODULE_TYPE, v)
		host_u.wr(9'h004, 16'h0000);
		host_u.rd(9'h004, v);
		`CHK("type_readonly", limit_monitor_pkg::MODULE_TYPE, v)
		host_u.rd(9'h100, v);
		`CHK("ctrl_reset", limit_monitor_pkg::CTRL_RST, v)
		host_u.rd(9'h007, v);
		`CHK("unmapped", 16'h0000, v)
		host_u.wr(9'h003, 16'h0001);
		host_u.rd(9'h003, v);
		`CHK("run", 16'h0001, v)
		$display("test regs done");
	endtask
	// upper limit 0 at 100, lower limit 1 at 50, shared hysteresis 10
	task automatic t_limits();
		logic [15:0] vals [6] = '{16'h0063, 16'h0064, 16'h005a, 16'h0059, 16'h0032, 16'h0033};
		logic [1:0] exps [6] = '{2'b00, 2'b01, 2'b01, 2'b00, 2'b10, 2'b00};
		host_u.wr(9'h101, 16'h000a);
		host_u.wr(9'h104, 16'h0064);
		host_u.wr(9'h105, 16'h0032);
		host_u.wr(9'h100, 16'h2013);
		host_u.wr(9'h002, 16'h0001);
		for (int i = 0; i < 6; i++)
		begin
			send(4'h0, vals[i]);
			`CHK("limit_image", exps[i], limit_image[1:0])
			`CHK("limit_image_inv", ~exps[i], limit_image_inv[1:0])
			`CHK("disabled_limits", 4'h0, {limit_image[3:2], limit_image_inv[3:2]})
			if (i == 1)
			begin
				host_u.rd(9'h103, v);
				`CHK("ch_status", 16'h0021, v)
			end
		end
		`CHK("limit_msgs", 4, host_u.lim_msgs)
		// message fields hold the last message: lower limit 1 of channel 0 released
		`CHK("last_msg_chan", 4'h0, msg_chan)
		`CHK("last_msg_limit", 2'h1, msg_limit)
		`CHK("last_msg_state", 1'b0, msg_state)
		host_u.rd(9'h005, v);
		`CHK("msg_time", 1'b1, msg_time != 32'h0000_0000 && msg_time[15:0] <= v)
		`CHK("irq_set", 1'b1, irq)
		irq_after_write(9'h001, 16'h0001, 1'b0);
		$display("test limits done");
	endtask
	task automatic t_subst();
		@(posedge core_clk);
		chan_fault <= 16'h0001;
		host_u.wr(9'h002, 16'h0000);
		host_u.wr(9'h100, 16'h3213);
		send(4'h0, 16'h0064);
		`CHK("subst_image", 2'b10, limit_image[1:0])
		`CHK("irq_masked", 1'b0, irq)
		host_u.rd(9'h000, v);
		`CHK("irq_status", 16'h0005, v)
		irq_after_write(9'h002, 16'h0004, 1'b1);
		irq_after_write(9'h001, 16'h0007, 1'b0);
		@(posedge core_clk);
		chan_fault <= 16'h0000;
		$display("test subst done");
	endtask
	// simulated 200 beats limit 150 while the real input stays 0
	task automatic t_sim();
		host_u.wr(9'h134, 16'h0096);
		host_u.wr(9'h132, 16'h00c8);
		host_u.wr(9'h130, 16'h4011);
		send(4'h3, 16'h0000);
		`CHK("sim_limit", 1'b1, limit_image[12])
		`CHK("sim_image", 16'h0008, sim_image)
		`CHK("sim_msgs", 1, host_u.sim_msgs)
		host_u.rd(9'h133, v);
		`CHK("sim_status", 16'h0101, v)
		// simulation off with signal messages on: limit, sim error, then sim signal
		host_u.wr(9'h130, 16'h2011);
		send(4'h3, 16'h0000);
		`CHK("real_limit", 1'b0, limit_image[12])
		`CHK("sim_image_off", 16'h0000, sim_image)
		`CHK("sim_msgs_off", 2, host_u.sim_msgs)
		`CHK("lim_msgs_sim", 6, host_u.lim_msgs)
		`CHK("sim_signal_kind", limit_monitor_pkg::MSG_SIM_SIGNAL, msg_kind)
		`CHK("sim_signal_chan", 4'h3, msg_chan)
		host_u.rd(9'h000, v);
		`CHK("irq_sim_status", 16'h0003, v)
		$display("test sim done");
	endtask
	// ==========================================================
	// main sequence
	initial
	begin
		repeat (6) @(posedge core_clk);
		sys_rst <= 1'b0;
		repeat (2) @(posedge core_clk);
		t_regs();
		t_limits();
		t_subst();
		t_sim();
		close_out();
	end
endmodule
